// ---- bench/spread_top_test.sv ----
// Purpose: self-checking bench for the spread-spectrum register block
// Assumes: AHB-Lite single word transfers, short triangle (HALF_CYC 40)
// Notes:   presets, offsets and timing follow the hand-over contract
`timescale 1ns/1ns
module spread_top_test;
    import spread_pkg::*;

    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    logic clk_sys, rst_b, hsel, hwrite, roleTxPin, monitorOn;
    logic [31:0] haddr, hwdata, hrdata, rdVal;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    logic hreadyout, hresp, linkResetPulse;
    logic [PHASE_W-1:0] serialTxPhase, camRefPhase, prevPhase, stepD;
    logic [7:0] cmuMult;
    int fails, cmp_count, cycles, n, moveCnt;
    // expected byte sets, byte0 in the top bits
    logic [63:0] presetTbl [5] = '{
        64'h0307_C902_F901_0000, 64'h0306_AB00_6307_0000,
        64'h0303_AB00_6307_0000, 64'h0301_F900_2C05_0000,
        64'h0301_AB00_6307_0000};

    assign hready = hreadyout;

    spread_top #(.HALF_CYC(40)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .roleTxPin(roleTxPin),
        .serialTxPhase(serialTxPhase), .camRefPhase(camRefPhase),
        .cmuMult(cmuMult), .linkResetPulse(linkResetPulse));

    // ------------------------------------------------------------
    // clock, timeout and phase step monitor
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // phase output may move at most one code per cycle
    always @(posedge clk_sys) begin
        cycles++;
        stepD = serialTxPhase - prevPhase;
        prevPhase = serialTxPhase;
        if (monitorOn) begin
            check("phaseStep", 32'(stepD <= 10'h001 || stepD == 10'h3FF),
                32'h1);
            if (stepD != '0) moveCnt++; // count phase code moves
        end
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one single transfer, entered right after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
        check("hresp", 32'(hresp), 32'(HRESP_OKAY));
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, {24'h000000, d}, unused);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        xfer(1'b0, a, 32'h00000000, v);
    endtask : rd

    // load one preset into a channel, byte by byte
    task automatic loadPreset(input int ch, input int lvl);
        for (int k = 0; k < 8; k++) begin
            wr(32'(ch * 64 + k * 4), presetTbl[lvl][63 - 8 * k -: 8]);
        end
    endtask : loadPreset

    task automatic stop_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        roleTxPin = 1'b1;
        monitorOn = 1'b0;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (4) @(posedge clk_sys); // clock runs before release
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // reset state
        check("cmuMult", 32'(cmuMult), 32'h000000F0);
        rd(32'h00000020, rdVal);
        check("ctrlReset", rdVal, 32'h00000000);
        rd(32'h00000000, rdVal);
        check("cfgReset", rdVal, 32'h00000000);
        // every level on the camera channel, reverse channel status untouched
        for (int i = 0; i < 5; i++) begin
            loadPreset(2, i);
            rd(32'h000000A4, rdVal);
            check("levelCode", rdVal, 32'((i + 1) << 4));
            rd(32'h00000088, rdVal);
            check("cfgByte2", rdVal, 32'(presetTbl[i][47:40]));
            rd(32'h00000064, rdVal);
            check("revStatus", rdVal, 32'h00000000);
        end
        wr(32'h00000080, 8'h04);
        rd(32'h000000A4, rdVal);
        check("noMatch", rdVal, 32'h00000000);
        // unmapped place
        wr(32'h000000E0, 8'h5A);
        rd(32'h000000E0, rdVal);
        check("unmapped", rdVal, 32'h00000000);
        // forward channel: disabled while loading, then enabled
        wr(32'h00000020, 8'h00);
        loadPreset(0, 4);
        wr(32'h00000020, 8'h01);
        rd(32'h00000020, rdVal);
        check("ctrlEn", rdVal, 32'h00000001);
        monitorOn = 1'b1;
        n = 0;
        do begin
            rd(32'h00000024, rdVal);
            n++;
        end while (rdVal[0] !== 1'b1 && n < 20);
        check("fwdStatus", rdVal, 32'h00000051);
        n = moveCnt;
        repeat (300) @(posedge clk_sys);
        check("fwdMoves", 32'(moveCnt > n), 32'h1);
        check("camIdle", 32'(camRefPhase), 32'h00000000);
        // receive end uses the reverse channel, which is idle
        monitorOn = 1'b0;
        roleTxPin <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check("revIdle0", 32'(serialTxPhase), 32'h00000000);
        repeat (100) @(posedge clk_sys);
        check("revIdle", 32'(serialTxPhase), 32'h00000000);
        roleTxPin <= 1'b1;
        repeat (10) @(posedge clk_sys);
        monitorOn = 1'b1;
        // link reset pulse, registers kept
        wr(32'h000000C0, 8'h01);
        #1;
        check("rstPulseHi", 32'(linkResetPulse), 32'h1);
        @(posedge clk_sys);
        #1;
        check("rstPulseLo", 32'(linkResetPulse), 32'h0);
        @(posedge clk_sys);
        rd(32'h000000C0, rdVal);
        check("rstRead", rdVal, 32'h00000000);
        rd(32'h00000020, rdVal);
        check("ctrlKept", rdVal, 32'h00000001);
        // disable ramps the spread down, no instant stop
        wr(32'h00000020, 8'h00);
        rd(32'h00000024, rdVal);
        check("rampDown", 32'(rdVal[0]), 32'h1);
        n = 0;
        do begin
            rd(32'h00000024, rdVal);
            n++;
        end while (rdVal[0] !== 1'b0 && n < 1500);
        check("stopped", rdVal, 32'h00000050);
        // link reset after stopping the spread
        wr(32'h000000C0, 8'h01);
        #1;
        check("rstAfterStop", 32'(linkResetPulse), 32'h1);
        @(posedge clk_sys);
        stop_test();
    end
endmodule : spread_top_test

// ---- rtl/spread_gen.sv ----
// Purpose: one triangle-profile phase command generator
// Assumes: cfg comes from registers on the same clock
// Notes:   gain slews one step a cycle so the spread never jumps
`timescale 1ns/1ns
module spread_gen
    import spread_pkg::*;
#(
    parameter int HALF_CYC = MOD_HALF_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // configuration in
    input genCfg_t cfg,
    // phase command and state out
    output logic [PHASE_W-1:0] phaseCmd,
    output genStat_t stat
);
    localparam int TRI_W = $clog2(HALF_CYC) + 1;
    localparam int PRD_W = TRI_W + 13;
    localparam logic signed [TRI_W-1:0] TRI_LIM = TRI_W'(HALF_CYC / 2);

    logic signed [TRI_W-1:0] tri_q, tri_d;
    logic up_q, up_d;
    ppm_t gain_q, gain_d, target;
    logic [ACC_W-1:0] phase_q, phase_d;
    logic signed [PRD_W-1:0] freq;

    // triangle, gain slew and quadratic phase accumulation
    always_comb begin
        up_d = up_q;
        tri_d = up_q ? TRI_W'(tri_q + 1) : TRI_W'(tri_q - 1);
        if (tri_d == TRI_LIM) up_d = 1'b0;
        if (tri_d == -TRI_LIM) up_d = 1'b1;
        target = (cfg.enable && cfg.ppm <= MAX_PPM) ? cfg.ppm : '0;
        gain_d = gain_q;
        if (gain_q < target) gain_d = ppm_t'(gain_q + 1);
        else if (gain_q > target) gain_d = ppm_t'(gain_q - 1);
        freq = PRD_W'(tri_q) * $signed({1'b0, gain_q});
        phase_d = ACC_W'(phase_q + ACC_W'(freq));
    end

    // state registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tri_q <= '0;
            up_q <= 1'b1;
            gain_q <= '0;
            phase_q <= '0;
        end else begin
            tri_q <= tri_d;
            up_q <= up_d;
            gain_q <= gain_d;
            phase_q <= phase_d;
        end
    end

    assign phaseCmd = phase_q[ACC_W-1 -: PHASE_W];
    assign stat = '{active: (gain_q != '0), gain: gain_q};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [TRI_W+1:0] perCnt_q;
    logic seenPeak_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            perCnt_q <= '0;
            seenPeak_q <= 1'b0;
        end else begin
            perCnt_q <= (tri_q == TRI_LIM) ? '0 : (TRI_W+2)'(perCnt_q + 1);
            if (tri_q == TRI_LIM) seenPeak_q <= 1'b1;
        end
    end

    a_gain_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
        gain_q <= MAX_PPM) else $error("spread above limit");
    a_gain_slew: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 (gain_q == $past(gain_q) || gain_q == $past(gain_q) + 1 ||
        gain_q == $past(gain_q) - 1)) else $error("gain jumped");
    a_phase_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 phase_q == ACC_W'($past(phase_q) + ACC_W'($past(freq))))
        else $error("phase not accumulated");
    a_mod_period: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tri_q == TRI_LIM && seenPeak_q) |->
        perCnt_q == (TRI_W+2)'(2 * HALF_CYC - 1))
        else $error("modulation period wrong");
    a_stop_drain: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!cfg.enable && gain_q != '0) |=> gain_q == $past(gain_q) - 1)
        else $error("gain not draining");
    c_full_spread: cover property (@(posedge clk_sys) disable iff (!rst_b)
        gain_q == MAX_PPM);
    c_drain_done: cover property (@(posedge clk_sys) disable iff (!rst_b)
        !cfg.enable ##1 stat.active ##1 !stat.active);
endmodule : spread_gen

// ---- rtl/spread_pkg.sv ----
// Purpose: shared constants and types for the spread-spectrum generator
// Assumes: 250 MHz system clock, 25 MHz reference, AHB-Lite register bus
// Notes:   byte presets are packed with the first config byte in the MSBs
package spread_pkg;
    // ------------------------------------------------------------
    // clocking and modulation timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_KHZ = 250000;
    localparam int MOD_RATE_KHZ = 25;
    localparam int MOD_HALF_CYC = SYS_CLK_KHZ / MOD_RATE_KHZ / 2;
    localparam int REF_CLK_MHZ = 25;
    localparam int CMU_CLK_MHZ = 6000;
    localparam logic [7:0] CMU_MULT = 8'(CMU_CLK_MHZ / REF_CLK_MHZ);
    localparam int PHASE_W = 10;
    localparam int ACC_W = 32;

    // ------------------------------------------------------------
    // spread levels
    // ------------------------------------------------------------
    localparam int NUM_CHAN = 3;
    localparam int NUM_LEVELS = 5;
    localparam int CFG_BYTES = 8;
    typedef logic [11:0] ppm_t;
    localparam ppm_t MAX_PPM = 12'h9E2;
    localparam logic [63:0] PRESET_CFG [NUM_LEVELS] = '{
        64'h0307_C902_F901_0000, 64'h0306_AB00_6307_0000,
        64'h0303_AB00_6307_0000, 64'h0301_F900_2C05_0000,
        64'h0301_AB00_6307_0000};
    localparam ppm_t PRESET_PPM [NUM_LEVELS] = '{
        12'h10C, 12'h244, 12'h3CA, 12'h6D6, 12'h9E2};

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_IDX = 4'h8;
    localparam logic [3:0] STAT_IDX = 4'h9;
    localparam logic [1:0] GLOBAL_CH = 2'h3;
    localparam logic [5:0] LINK_RST_OFS = 6'h00;
    localparam int EN_BIT = 0;
    localparam int RST_BIT = 0;
    localparam int LVL_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum {CH_FWD, CH_REV, CH_CAM} chan_t;
    typedef struct packed {
        logic enable;
        ppm_t ppm;
    } genCfg_t;
    typedef struct packed {
        logic active;
        ppm_t gain;
    } genStat_t;
endpackage : spread_pkg

// ---- rtl/spread_top.sv ----
// Purpose: AHB-Lite register file and three spread generators
// Assumes: single word transfers, role pin from outside the clock domain
// Notes:   reads take one wait state, writes none
//
// How it works
// - five levels, all at 25 kHz triangle
// - quadratic phase commands steer 6 GHz interpolator
// - control bit zero starts and stops modulation
// - transmit end drives forward, receive end reverse
// - spread never exceeds 2530 ppm
// - each level picked by eight fixed bytes
// - no abrupt phase steps on level or enable change; a role change switches channel at once
// - forward, reverse, camera reference configured independently
// - clocks multiplied from 25 MHz, source independent
// - self-clearing link reset keeps register contents
`timescale 1ns/1ns
module spread_top
    import spread_pkg::*;
#(
    parameter int HALF_CYC = MOD_HALF_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // device role strap pin, high on the transmitting end
    input wire logic roleTxPin,
    // phase commands and link control
    output logic [PHASE_W-1:0] serialTxPhase,
    output logic [PHASE_W-1:0] camRefPhase,
    output logic [7:0] cmuMult,
    output logic linkResetPulse
);
    // ------------------------------------------------------------
    // role pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] roleSync_q, roleSync_d;
    logic roleTx_q, roleTx_d;

    // three-stage sync, change accepted when stages two and three agree
    always_comb begin
        roleSync_d = {roleSync_q[1:0], roleTxPin};
        roleTx_d = (roleSync_q[1] == roleSync_q[2]) ? roleSync_q[2]
                                                    : roleTx_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            roleSync_q <= '0;
            roleTx_q <= 1'b0;
        end else begin
            roleSync_q <= roleSync_d;
            roleTx_q <= roleTx_d;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite bus phases
    // ------------------------------------------------------------
    logic apValid_q, apValid_d;
    logic apWrite_q, apWrite_d;
    logic [31:0] apAddr_q, apAddr_d;
    logic rdDone_q, rdDone_d;
    logic [31:0] rdData_q, rdData_d;
    logic wrStb;
    logic [1:0] apCh;
    logic [3:0] apIdx;
    logic apHit;

    assign apCh = apAddr_q[7:6];
    assign apIdx = apAddr_q[5:2];
    assign apHit = (apAddr_q[31:8] == '0) && (apAddr_q[1:0] == '0);
    assign wrStb = apValid_q && apWrite_q;

    // capture address phase, one wait state on reads
    always_comb begin
        apValid_d = apValid_q;
        apWrite_d = apWrite_q;
        apAddr_d = apAddr_q;
        if (hready) begin
            apValid_d = hsel && (htrans == HTRANS_NONSEQ);
            apWrite_d = hwrite;
            apAddr_d = haddr;
        end
        rdDone_d = apValid_q && !apWrite_q && !rdDone_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            apValid_q <= 1'b0;
            apWrite_q <= 1'b0;
            apAddr_q <= '0;
            rdDone_q <= 1'b0;
        end else begin
            apValid_q <= apValid_d;
            apWrite_q <= apWrite_d;
            apAddr_q <= apAddr_d;
            rdDone_q <= rdDone_d;
        end
    end

    assign hreadyout = !(apValid_q && !apWrite_q && !rdDone_q);
    assign hresp = HRESP_OKAY;
    assign hrdata = rdData_q;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] cfg_q [NUM_CHAN][CFG_BYTES];
    logic [7:0] cfg_d [NUM_CHAN][CFG_BYTES];
    logic [7:0] ctrl_q [NUM_CHAN];
    logic [7:0] ctrl_d [NUM_CHAN];
    logic linkRst_q, linkRst_d;
    genStat_t gStat [NUM_CHAN];
    logic [2:0] level [NUM_CHAN];

    // byte writes to config, control and link reset
    always_comb begin
        cfg_d = cfg_q;
        ctrl_d = ctrl_q;
        linkRst_d = 1'b0; // self-clearing
        if (wrStb && apHit) begin
            if (apCh == GLOBAL_CH) begin
                if (apAddr_q[5:0] == LINK_RST_OFS)
                    linkRst_d = hwdata[RST_BIT];
            end else if (apIdx == CTRL_IDX) begin
                ctrl_d[apCh] = hwdata[7:0];
            end else if (apIdx < CTRL_IDX) begin
                cfg_d[apCh][apIdx[2:0]] = hwdata[7:0];
            end
        end
    end

    // read mux, unmapped and reserved read as zero
    always_comb begin
        rdData_d = rdData_q;
        if (rdDone_d) begin
            rdData_d = '0;
            if (apHit && apCh != GLOBAL_CH) begin
                if (apIdx < CTRL_IDX)
                    rdData_d[7:0] = cfg_q[apCh][apIdx[2:0]];
                else if (apIdx == CTRL_IDX)
                    rdData_d[7:0] = ctrl_q[apCh];
                else if (apIdx == STAT_IDX)
                    rdData_d[7:0] = {1'b0, level[apCh], 3'h0,
                                     gStat[apCh].active};
            end
        end
    end

    // registers keep contents across link reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                ctrl_q[c] <= CTRL_RESET;
                for (int b = 0; b < CFG_BYTES; b++)
                    cfg_q[c][b] <= CFG_RESET;
            end
            linkRst_q <= 1'b0;
            rdData_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            ctrl_q <= ctrl_d;
            linkRst_q <= linkRst_d;
            rdData_q <= rdData_d;
        end
    end

    // ------------------------------------------------------------
    // per-channel preset decode and generator
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] chPhase [NUM_CHAN];
    genCfg_t gCfg [NUM_CHAN];

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        logic [63:0] bytesFlat;
        ppm_t ppm;
        logic [2:0] lvl;

        // match written bytes against the fixed presets
        always_comb begin
            bytesFlat = '0;
            for (int b = 0; b < CFG_BYTES; b++)
                bytesFlat[63-8*b -: 8] = cfg_q[c][b];
            ppm = '0;
            lvl = '0;
            for (int l = 0; l < NUM_LEVELS; l++) begin
                if (bytesFlat == PRESET_CFG[l]) begin
                    ppm = PRESET_PPM[l];
                    lvl = 3'(l + 1);
                end
            end
        end

        assign level[c] = lvl;
        assign gCfg[c] = '{enable: ctrl_q[c][EN_BIT], ppm: ppm};

        spread_gen #(.HALF_CYC(HALF_CYC)) u_gen (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .cfg(gCfg[c]),
            .phaseCmd(chPhase[c]),
            .stat(gStat[c])
        );

        a_level_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
            bytesFlat == PRESET_CFG[NUM_LEVELS-1] |-> ppm == MAX_PPM)
            else $error("top preset not decoded");
    end

    // ------------------------------------------------------------
    // output routing
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] txPhase_q, txPhase_d;
    logic [PHASE_W-1:0] camPhase_q, camPhase_d;

    // transmit end sends forward settings, receive end reverse
    always_comb begin
        txPhase_d = roleTx_q ? chPhase[CH_FWD] : chPhase[CH_REV];
        camPhase_d = chPhase[CH_CAM];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            txPhase_q <= '0;
            camPhase_q <= '0;
        end else begin
            txPhase_q <= txPhase_d;
            camPhase_q <= camPhase_d;
        end
    end

    assign serialTxPhase = txPhase_q;
    assign camRefPhase = camPhase_q;
    assign cmuMult = CMU_MULT; // fixed, no source select
    assign linkResetPulse = linkRst_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rst_oneshot: assert property (@(posedge clk_sys) disable iff (!rst_b)
        linkResetPulse |=> !linkResetPulse)
        else $error("link reset not one cycle");
    a_rst_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wrStb && apHit && apCh == GLOBAL_CH && apAddr_q[5:0] == LINK_RST_OFS
        && hwdata[RST_BIT]) |=> linkResetPulse)
        else $error("link reset write lost");
    a_role_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 serialTxPhase == ($past(roleTx_q) ? $past(chPhase[CH_FWD])
        : $past(chPhase[CH_REV]))) else $error("wrong link phase");
    a_ctrl_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wrStb && apHit && apCh != GLOBAL_CH && apIdx == CTRL_IDX)
        |=> gCfg[$past(apCh)].enable == $past(hwdata[EN_BIT]))
        else $error("enable not applied");
    a_cmu_fixed: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmuMult == 8'(CMU_CLK_MHZ / REF_CLK_MHZ))
        else $error("multiplier changed");
    c_read_wait: cover property (@(posedge clk_sys) disable iff (!rst_b)
        !hreadyout ##1 hreadyout);
    c_link_reset: cover property (@(posedge clk_sys) disable iff (!rst_b)
        linkResetPulse);
endmodule : spread_top
